/* core/peripheral_dma_pkg.sv */
package peripheral_dma_pkg;

    localparam int          NUM_CHANNELS    = 24;

    localparam logic [11:0] OFF_RX_PTR      = 12'h100;
    localparam logic [11:0] OFF_RX_CNT      = 12'h104;
    localparam logic [11:0] OFF_TX_PTR      = 12'h108;
    localparam logic [11:0] OFF_TX_CNT      = 12'h10C;
    localparam logic [11:0] OFF_RX_NEXT_PTR = 12'h110;
    localparam logic [11:0] OFF_RX_NEXT_CNT = 12'h114;
    localparam logic [11:0] OFF_TX_NEXT_PTR = 12'h118;
    localparam logic [11:0] OFF_TX_NEXT_CNT = 12'h11C;
    localparam logic [11:0] OFF_CTRL        = 12'h120;
    localparam logic [11:0] OFF_STATUS      = 12'h124;

    // Register kind from offset bits 4 and 2, direction from bit 3
    localparam logic [1:0]  KIND_CUR_PTR    = 2'h0;
    localparam logic [1:0]  KIND_CUR_CNT    = 2'h1;
    localparam logic [1:0]  KIND_NEXT_PTR   = 2'h2;
    localparam logic [1:0]  KIND_NEXT_CNT   = 2'h3;

    localparam int          CTRL_RX_EN      = 0;
    localparam int          CTRL_RX_DIS     = 1;
    localparam int          CTRL_TX_EN      = 8;
    localparam int          CTRL_TX_DIS     = 9;
    localparam int          STAT_RX_EN      = 0;
    localparam int          STAT_TX_EN      = 8;

    localparam logic        DIR_RX          = 1'b0;
    localparam logic        DIR_TX          = 1'b1;

    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_HALF       = 2'h1;
    localparam logic [1:0]  SIZE_WORD       = 2'h2;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    localparam logic [31:0] PTR_RESET       = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET       = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_MEM,
        ST_PUT
    } state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_cmd_t;

endpackage : peripheral_dma_pkg

/* core/peripheral_dma_unit.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) Pointer advances 1, 2 or 4 bytes per byte, half-word or word unit.
// (R2) A pointer rewritten mid-transfer is used for the following units.
// (R3) The 16-bit current counter drops by one per moved unit.
// (R4) Current and next counters both zero: stop and raise the end flag.
// (R5) Current zero, next nonzero: next loads current, next then cleared. Code reloads in place of the unit taking current from 1.
// (R6) Receive end flag set at last memory write; nonzero receive count write clears.
// (R7) Transmit end flag set at last holding write; nonzero transmit count write clears.
// (R8) Receive full flag set when both receive counters zero; nonzero receive count write clears.
// (R9) Transmit empty flag set when both transmit counters zero; nonzero transmit count write clears.
// (R10) Full duplex programs both directions; half duplex programs one at a time.
// (R11) Half duplex shares one pointer and counter set, chosen by operating direction.
// (R12) Counter reads return the units still outstanding.
// (R13) Control register enables or disables each direction; status shows enables.
// (R14) Receive ready requests the matrix, reads holding register, writes memory.
// (R15) Transmit ready requests the matrix, reads memory, writes holding register.
// (R16) System has 24 channels; each holds current and next pointers and counters.
// (R17) End-of-transfer interrupt is raised by the served peripheral, not here.
// (R18) Ten registers sit at offsets 0x100 to 0x124 in every peripheral.
// (R19) Zero counter halts a direction; 1 to 65535 starts it when enabled.
// (R20) Unit width follows the peripheral character size for step and access.
module peripheral_dma_unit (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [11:0]                   awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [11:0]                   araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire logic                          half_duplex,
    input  wire logic                          tx_mode,
    input  wire logic [1:0]                    char_size,
    input  wire logic                          rx_ready,
    input  wire logic [31:0]                   rx_holding_reg,
    output logic                               rx_holding_read,
    input  wire logic                          tx_ready,
    output logic [31:0]                        tx_holding_reg,
    output logic                               tx_holding_write,
    output logic                               mem_req,
    input  wire logic                          mem_grant,
    output var peripheral_dma_pkg::mem_cmd_t   mem_cmd,
    input  wire logic [31:0]                   mem_rdata,
    input  wire logic                          mem_done,
    output logic                               rx_end_flag,
    output logic                               tx_end_flag,
    output logic                               rx_buffer_full_flag,
    output logic                               tx_buffer_empty_flag
);
    import peripheral_dma_pkg::*;

    // Storage index 0 serves receive, 1 transmit; half duplex keeps pointers and counters in index 0 only
    logic [31:0] cur_ptr  [2]; // [R16]
    logic [15:0] cur_cnt  [2];
    logic [31:0] next_ptr [2];
    logic [15:0] next_cnt [2];
    logic        xfer_en  [2];
    logic        end_flag [2];
    logic        buf_flag [2];
    state_t      state;
    logic        dir;
    logic [31:0] unit_buf;

    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    logic        wr_go;
    logic        wr_chan;
    logic        wr_idx;
    logic [1:0]  wr_kind;
    logic [31:0] wr_val;
    logic        adv;
    logic        ai;

    function automatic logic phys(input logic d);
        phys = half_duplex ? DIR_RX : d; // [R11] [R10]
    endfunction : phys

    function automatic logic [31:0] step_of(input logic [1:0] sz);
        case (sz)
            SIZE_HALF: step_of = 32'h0000_0002;
            SIZE_WORD: step_of = 32'h0000_0004;
            default:   step_of = 32'h0000_0001;
        endcase
    endfunction : step_of

    function automatic logic is_chan(input logic [11:0] a);
        is_chan = (a[11:5] == OFF_RX_PTR[11:5]) && (a[1:0] == 2'h0);
    endfunction : is_chan

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_chan(a) || (a == OFF_CTRL) || (a == OFF_STATUS); // [R18]
    endfunction : is_mapped

    function automatic logic [31:0] read_reg(input logic [11:0] a);
        logic p;
        p = phys(a[3]);
        read_reg = 32'h0000_0000;
        if (is_chan(a)) begin
            case ({a[4], a[2]})
                KIND_CUR_PTR:  read_reg = cur_ptr[p];
                KIND_CUR_CNT:  read_reg = {16'h0000, cur_cnt[p]}; // [R12]
                KIND_NEXT_PTR: read_reg = next_ptr[p];
                default:       read_reg = {16'h0000, next_cnt[p]};
            endcase
        end else if (a == OFF_STATUS) begin
            read_reg[STAT_RX_EN] = xfer_en[DIR_RX]; // [R13]
            read_reg[STAT_TX_EN] = xfer_en[DIR_TX];
        end
    endfunction : read_reg

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? nv[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    function automatic logic eligible(input logic d);
        logic rdy;
        rdy = (d == DIR_RX) ? rx_ready : tx_ready;
        eligible = xfer_en[d] && (cur_cnt[phys(d)] != CNT_RESET) && rdy // [R19]
                   && (!half_duplex || (tx_mode == d)); // [R11]
    endfunction : eligible

    // Register bus: write address and data taken in either order
    assign awready = !aw_held;
    assign wready  = !w_held;
    assign arready = !rvalid;
    assign wr_go   = aw_held && w_held && !bvalid;
    assign wr_chan = is_chan(aw_addr);
    assign wr_idx  = phys(aw_addr[3]);
    assign wr_kind = {aw_addr[4], aw_addr[2]};
    assign wr_val  = merge(read_reg(aw_addr), w_data, w_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= read_reg(araddr);
            rresp  <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Unit completes at the memory write (receive) or holding write (transmit)
    assign adv = ((state == ST_MEM) && mem_done && (dir == DIR_RX)) || (state == ST_PUT);
    assign ai  = phys(dir);

    // Software writes land after engine updates so a fresh pointer wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                cur_ptr[i]  <= PTR_RESET;
                cur_cnt[i]  <= CNT_RESET;
                next_ptr[i] <= PTR_RESET;
                next_cnt[i] <= CNT_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (adv && (ai == i)) begin
                    if ((cur_cnt[i] == 16'h0001) && (next_cnt[i] != CNT_RESET)) begin
                        cur_ptr[i]  <= next_ptr[i]; // [R5]
                        cur_cnt[i]  <= next_cnt[i];
                        next_ptr[i] <= PTR_RESET;
                        next_cnt[i] <= CNT_RESET;
                    end else begin
                        cur_ptr[i] <= cur_ptr[i] + step_of(char_size); // [R1] [R20]
                        cur_cnt[i] <= cur_cnt[i] - 16'h0001; // [R3]
                    end
                end
                if (wr_go && wr_chan && (wr_idx == i)) begin
                    case (wr_kind)
                        KIND_CUR_PTR:  cur_ptr[i]  <= wr_val; // [R2]
                        KIND_CUR_CNT:  cur_cnt[i]  <= wr_val[15:0]; // [R19]
                        KIND_NEXT_PTR: next_ptr[i] <= wr_val;
                        default:       next_cnt[i] <= wr_val[15:0];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_en[DIR_RX] <= 1'b0;
            xfer_en[DIR_TX] <= 1'b0;
        end else if (wr_go && (aw_addr == OFF_CTRL)) begin
            if (w_data[CTRL_RX_DIS]) begin
                xfer_en[DIR_RX] <= 1'b0; // [R13]
            end else if (w_data[CTRL_RX_EN]) begin
                xfer_en[DIR_RX] <= 1'b1;
            end
            if (w_data[CTRL_TX_DIS]) begin
                xfer_en[DIR_TX] <= 1'b0;
            end else if (w_data[CTRL_TX_EN]) begin
                xfer_en[DIR_TX] <= 1'b1;
            end
        end
    end

    // Completion flags: a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int d = 0; d < 2; d++) begin
                end_flag[d] <= 1'b0;
                buf_flag[d] <= 1'b0;
            end
        end else begin
            for (int d = 0; d < 2; d++) begin
                logic set_end;
                logic set_buf;
                logic clr;
                set_end = adv && (dir == d) && (cur_cnt[ai] == 16'h0001);
                set_buf = set_end && (next_cnt[ai] == CNT_RESET); // [R4]
                clr = wr_go && wr_chan && wr_kind[0] && (wr_idx == phys(d[0]))
                      && (wr_val[15:0] != CNT_RESET);
                end_flag[d] <= set_end || (end_flag[d] && !clr); // [R6] [R7]
                buf_flag[d] <= set_buf || (buf_flag[d] && !clr); // [R8] [R9]
            end
        end
    end

    // Flags go to the peripheral, which raises its own interrupt
    assign rx_end_flag          = end_flag[DIR_RX]; // [R17]
    assign tx_end_flag          = end_flag[DIR_TX];
    assign rx_buffer_full_flag  = buf_flag[DIR_RX];
    assign tx_buffer_empty_flag = buf_flag[DIR_TX];

    assign mem_req          = (state == ST_REQ);
    assign rx_holding_read  = (state == ST_REQ) && mem_grant && (dir == DIR_RX); // [R14]
    assign tx_holding_write = (state == ST_PUT); // [R15]
    assign tx_holding_reg   = unit_buf;

    // One unit at a time; receive has priority when both are ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ST_IDLE;
            dir      <= DIR_RX;
            unit_buf <= 32'h0000_0000;
            mem_cmd  <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (eligible(DIR_RX)) begin
                        dir   <= DIR_RX;
                        state <= ST_REQ;
                    end else if (eligible(DIR_TX)) begin
                        dir   <= DIR_TX;
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (!xfer_en[dir]) begin
                        state <= ST_IDLE;
                    end else if (mem_grant) begin
                        mem_cmd.valid <= 1'b1;
                        mem_cmd.write <= (dir == DIR_RX); // [R14] [R15]
                        mem_cmd.size  <= char_size; // [R20]
                        mem_cmd.addr  <= cur_ptr[ai];
                        mem_cmd.wdata <= (dir == DIR_RX) ? rx_holding_reg : 32'h0000_0000;
                        state         <= ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (mem_done) begin
                        mem_cmd.valid <= 1'b0;
                        if (dir == DIR_TX) begin
                            unit_buf <= mem_rdata;
                            state    <= ST_PUT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_PUT: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rx_grant;
        (state == ST_REQ) && mem_grant && xfer_en[dir] && (dir == DIR_RX);
    endsequence

    sequence s_tx_fetched;
        (state == ST_MEM) && mem_done && (dir == DIR_TX);
    endsequence

    sequence s_plain_adv;
        adv && !wr_go && !((cur_cnt[ai] == 16'h0001) && (next_cnt[ai] != CNT_RESET));
    endsequence

    a_ptr_step: assert property (s_plain_adv |=> // [R1]
        cur_ptr[$past(ai)] == $past(cur_ptr[ai]) + step_of($past(char_size)))
        else $error("pointer step wrong");

    a_cnt_dec: assert property (s_plain_adv |=> // [R3]
        cur_cnt[$past(ai)] == $past(cur_cnt[ai]) - 16'h0001)
        else $error("counter not decremented");

    a_end_stop: assert property ( // [R4]
        (adv && !wr_go && (cur_cnt[ai] == 16'h0001) && (next_cnt[ai] == CNT_RESET))
        |=> end_flag[$past(dir)] && buf_flag[$past(dir)] && (state == ST_IDLE)
        ##1 !((state == ST_REQ) && (dir == $past(dir, 2))))
        else $error("channel did not stop at end");

    a_reload: assert property ( // [R5]
        (adv && !wr_go && (cur_cnt[ai] == 16'h0001) && (next_cnt[ai] != CNT_RESET))
        |=> (cur_cnt[$past(ai)] == $past(next_cnt[ai])) && (next_cnt[$past(ai)] == CNT_RESET)
        && (cur_ptr[$past(ai)] == $past(next_ptr[ai])))
        else $error("next set not reloaded");

    a_flag_clear: assert property ( // [R6]
        (wr_go && wr_chan && wr_kind[0] && (wr_val[15:0] != CNT_RESET) && !adv)
        |=> !end_flag[$past(aw_addr[3])])
        else $error("end flag not cleared");

    a_rx_order: assert property (s_rx_grant |-> rx_holding_read ##1 // [R14]
        (mem_cmd.valid && mem_cmd.write && (mem_cmd.wdata == $past(rx_holding_reg))))
        else $error("receive unit not written to memory");

    a_tx_put: assert property (s_tx_fetched |=> // [R15]
        tx_holding_write && (tx_holding_reg == $past(mem_rdata)) ##1 !tx_holding_write)
        else $error("transmit unit not put to holding register");

    a_enable_ctl: assert property ( // [R13]
        (wr_go && (aw_addr == OFF_CTRL) && w_data[CTRL_TX_DIS]) |=> !xfer_en[DIR_TX])
        else $error("disable not applied");

    a_zero_halt: assert property ( // [R19]
        (state == ST_IDLE) && (cur_cnt[phys(DIR_RX)] == CNT_RESET)
        && (cur_cnt[phys(DIR_TX)] == CNT_RESET) |=> (state == ST_IDLE))
        else $error("transfer started on zero count");

    a_half_share: assert property ( // [R11]
        ((state == ST_IDLE) && half_duplex ##1 (state == ST_REQ))
        |-> (dir == $past(tx_mode)))
        else $error("half duplex direction mismatch");
endmodule : peripheral_dma_unit

`default_nettype wire

/* verification/dma_far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_far_side_model (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        slow,
    input  wire logic                        mem_req,
    input  wire peripheral_dma_pkg::mem_cmd_t mem_cmd,
    output logic                             mem_grant,
    output logic [31:0]                      mem_rdata,
    output logic                             mem_done
);
    import peripheral_dma_pkg::*;
    logic [2:0] wait_cnt;
    // Matrix grant and memory access, each followed by a pause when slow
    always @(posedge aclk) begin
        mem_grant <= 1'b0;
        mem_done <= 1'b0;
        // Read bus not held once the access is over
        mem_rdata <= ~mem_rdata;
        if (!aresetn) begin
            wait_cnt <= 3'h0;
            mem_rdata <= 32'h5A5A_5A5A;
        end else if (wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end else if (mem_req && !mem_grant) begin
            mem_grant <= 1'b1;
            wait_cnt <= slow ? 3'h3 : 3'h0;
        end else if (mem_cmd.valid && !mem_done) begin
            mem_done <= 1'b1;
            mem_rdata <= {mem_cmd.addr[15:0], ~mem_cmd.addr[15:0]};
            wait_cnt <= slow ? 3'h3 : 3'h0;
        end
    end
endmodule : dma_far_side_model
`default_nettype wire

/* verification/peripheral_dma_channel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module peripheral_dma_channel_tb;
    import peripheral_dma_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic        half_duplex, tx_mode, rx_ready, tx_ready, awready, wready, bvalid;
    logic        arready, rvalid, rx_holding_read, tx_holding_write, mem_req, mem_grant;
    logic        mem_done, rx_end_flag, tx_end_flag, rx_buffer_full_flag, tx_buffer_empty_flag;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rx_holding_reg, tx_holding_reg, mem_rdata, p, step;
    logic [3:0]  wstrb;
    logic [1:0]  char_size, bresp, rresp;
    mem_cmd_t    mem_cmd;
    logic [35:0] exp_q[$];
    int          seed, bad_count, compares;

    peripheral_dma_unit peripheral_dma_unit_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .half_duplex, .tx_mode, .char_size,
        .rx_ready, .rx_holding_reg, .rx_holding_read, .tx_ready, .tx_holding_reg,
        .tx_holding_write, .mem_req, .mem_grant, .mem_cmd, .mem_rdata, .mem_done,
        .rx_end_flag, .tx_end_flag, .rx_buffer_full_flag, .tx_buffer_empty_flag);
    dma_far_side_model dma_far_side_model_i (.aclk, .aresetn, .slow, .mem_req, .mem_cmd,
        .mem_grant, .mem_rdata, .mem_done);

    always #2.5 aclk = ~aclk;

    function automatic logic [31:0] mask_of(input logic [1:0] s);
        return (s == SIZE_BYTE) ? 32'hFF : (s == SIZE_HALF) ? 32'hFFFF : 32'hFFFF_FFFF;
    endfunction : mask_of

    task automatic push(input logic [3:0] k, input logic [31:0] v);
        exp_q.push_back({k, v});
    endtask : push

    task automatic check_next(input logic [3:0] k, input logic [31:0] v);
        logic [35:0] e;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 36'hF_0000_0000;
        `CHK("result kind", e[35:32], k)
        `CHK("result value", e[31:0], v)
    endtask : check_next

    // Oldest note is compared whenever a result appears
    always @(posedge aclk) begin
        if (aresetn) begin
            if (bvalid && bready) check_next(4'h0, {30'h0, bresp});
            if (rvalid && rready) check_next(4'h1, rdata);
            if (rvalid && rready) `CHK("read resp", RESP_OKAY, rresp)
            if (mem_cmd.valid && mem_done && mem_cmd.write) begin
                check_next(4'h2, mem_cmd.addr);
                check_next(4'h3, mem_cmd.wdata & mask_of(char_size));
                `CHK("unit size", char_size, mem_cmd.size)
            end
            if (tx_holding_write) check_next(4'h4, tx_holding_reg & mask_of(char_size));
        end
    end

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        push(4'h0, {30'h0, r});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] e);
        push(4'h1, e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask : axi_read

    task automatic rx_unit(input logic [31:0] a);
        logic [31:0] v;
        v = $random(seed);
        push(4'h2, a);
        push(4'h3, v & mask_of(char_size));
        @(posedge aclk);
        rx_holding_reg <= v;
        rx_ready <= 1'b1;
        do @(posedge aclk); while (!rx_holding_read);
        rx_ready <= 1'b0;
        rx_holding_reg <= ~v;
        do @(posedge aclk); while (!(mem_cmd.valid && mem_done));
        repeat (2) @(posedge aclk);
    endtask : rx_unit

    task automatic tx_unit(input logic [31:0] a);
        push(4'h4, {a[15:0], ~a[15:0]} & mask_of(char_size));
        @(posedge aclk);
        tx_ready <= 1'b1;
        do @(posedge aclk); while (!tx_holding_write);
        tx_ready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : tx_unit

    task automatic summarize;
        if (exp_q.size() != 0) bad_count++;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        summarize();
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
        {half_duplex, tx_mode, rx_ready, tx_ready, awaddr, araddr, wdata} = '0;
        {rx_holding_reg, char_size} = '0;
        wstrb = 4'hF;
        seed = 84;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 10; i++) axi_read(OFF_RX_PTR + 12'(4 * i), 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            p = $random(seed);
            axi_write(OFF_RX_PTR + 12'(4 * i), p, RESP_OKAY);
            axi_read(OFF_RX_PTR + 12'(4 * i), i[0] ? {16'h0, p[15:0]} : p);
            axi_write(OFF_RX_PTR + 12'(4 * i), 32'h0, RESP_OKAY);
        end
        axi_write(12'h128, 32'h1, RESP_SLVERR);
        axi_write(12'h0FC, 32'h1, RESP_SLVERR);
        axi_write(OFF_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        axi_read(OFF_STATUS, 32'h0);
        axi_write(OFF_CTRL, 32'h101, RESP_OKAY);
        axi_read(OFF_STATUS, 32'h101);
        axi_write(OFF_CTRL, 32'h303, RESP_OKAY);
        axi_read(OFF_STATUS, 32'h0);
        wstrb <= 4'h2;
        axi_write(OFF_TX_NEXT_PTR, 32'h1234_5678, RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(OFF_TX_NEXT_PTR, 32'h0000_5600);
        axi_write(OFF_RX_CNT, 32'h1, RESP_OKAY);
        rx_ready <= 1'b1;
        repeat (8) @(posedge aclk);
        rx_ready <= 1'b0;
        axi_read(OFF_RX_CNT, 32'h1);
        $display("test registers done");
        for (int s = 0; s < 3; s++) begin
            p = 32'h2000_0000 + 32'(s * 256);
            step = 32'h1 << s;
            char_size <= 2'(s);
            axi_write(OFF_RX_PTR, p, RESP_OKAY);
            axi_write(OFF_RX_CNT, 32'h3, RESP_OKAY);
            axi_write(OFF_RX_NEXT_PTR, p + 32'h80, RESP_OKAY);
            axi_write(OFF_RX_NEXT_CNT, 32'h1, RESP_OKAY);
            axi_write(OFF_CTRL, 32'h1, RESP_OKAY);
            rx_unit(p);
            rx_unit(p + step);
            axi_read(OFF_RX_CNT, 32'h1);
            axi_write(OFF_RX_PTR, p + 32'h40, RESP_OKAY);
            rx_unit(p + 32'h40);
            rx_unit(p + 32'h80);
            axi_read(OFF_RX_PTR, p + 32'h80 + step);
            axi_read(OFF_RX_NEXT_PTR, 32'h0);
            `CHK("rx flags", 2'b11, {rx_end_flag, rx_buffer_full_flag})
            rx_ready <= 1'b1;
            repeat (6) begin
                @(posedge aclk);
                `CHK("mem_req", 1'b0, mem_req)
            end
            rx_ready <= 1'b0;
            axi_write(OFF_CTRL, 32'h2, RESP_OKAY);
            axi_write(OFF_RX_CNT, 32'h5, RESP_OKAY);
            `CHK("rx flags", 2'b00, {rx_end_flag, rx_buffer_full_flag})
            axi_write(OFF_RX_CNT, 32'h0, RESP_OKAY);
        end
        $display("test receive done");
        slow <= 1'b1;
        char_size <= SIZE_HALF;
        axi_write(OFF_TX_PTR, 32'h4000_0010, RESP_OKAY);
        axi_write(OFF_TX_CNT, 32'h2, RESP_OKAY);
        axi_write(OFF_CTRL, 32'h100, RESP_OKAY);
        tx_unit(32'h4000_0010);
        tx_unit(32'h4000_0012);
        `CHK("tx flags", 2'b11, {tx_end_flag, tx_buffer_empty_flag})
        axi_write(OFF_CTRL, 32'h200, RESP_OKAY);
        axi_write(OFF_TX_NEXT_CNT, 32'h4, RESP_OKAY);
        `CHK("tx flags", 2'b00, {tx_end_flag, tx_buffer_empty_flag})
        $display("test transmit done");
        half_duplex <= 1'b1;
        tx_mode <= 1'b1;
        axi_write(OFF_TX_PTR, 32'h5000_0000, RESP_OKAY);
        axi_read(OFF_RX_PTR, 32'h5000_0000);
        axi_write(OFF_TX_CNT, 32'h1, RESP_OKAY);
        axi_write(OFF_CTRL, 32'h101, RESP_OKAY);
        tx_unit(32'h5000_0000);
        $display("test half_duplex done");
        summarize();
    end
endmodule : peripheral_dma_channel_tb
`default_nettype wire
